// ### hdl/asm_defines.vh
`ifndef ASM_DEFINES_VH
`define ASM_DEFINES_VH

`define ASM_CLK_PERIOD_NS 10
`define ASM_ADDR_W 20
`define ASM_DATA_W 8

// Timing in ns, slow grade (covers both grades)
`define ASM_SELECT_TO_WRITE_END_NS 40
`define ASM_ADDRESS_SETUP_TO_WRITE_END_NS 40
`define ASM_DATA_SETUP_TO_WRITE_END_NS 28
`define ASM_WRITE_STROBE_WIDTH_NS 40
`define ASM_STROBE_TO_FLOAT_DELAY_NS 18
`define ASM_SELECT_ACCESS_DELAY_NS 55
`define ASM_DESELECT_TO_FLOAT_NS 18
`define ASM_GATE_OFF_TO_FLOAT_NS 18

// Least times round up
`define ASM_CEIL_CYC(ns) (((ns) + `ASM_CLK_PERIOD_NS - 1) / `ASM_CLK_PERIOD_NS)

// Float wait, then data setup: strobe held low for float + setup
`define ASM_FLOAT_CYC `ASM_CEIL_CYC(`ASM_STROBE_TO_FLOAT_DELAY_NS)
`define ASM_SETUP_CYC `ASM_CEIL_CYC(`ASM_DATA_SETUP_TO_WRITE_END_NS)
`define ASM_STROBE_CYC `ASM_CEIL_CYC(`ASM_WRITE_STROBE_WIDTH_NS)
`define ASM_READ_CYC (`ASM_CEIL_CYC(`ASM_SELECT_ACCESS_DELAY_NS) + 1)
`define ASM_TURN_CYC `ASM_CEIL_CYC(`ASM_DESELECT_TO_FLOAT_NS)

`endif

// ### hdl/asm_ctrl.v
// Operation
// - Write happens only while both selects active and write strobe low together.
// - Write ends when either select or the write strobe goes inactive.
// - Time data setup and hold against the edge that ends the write.
// - Hold both selects active at least 40 ns before write end.
// - Present stable address at least 40 ns before write end.
// - Address may change right after write end; zero hold.
// - Drive write data at least 28 ns before write end.
// - Write data may be released at write end; zero hold.
// - Strobe low at least 40 ns, and over float delay plus setup.
// - Address clean and known throughout every active cycle.
// - Write strobe stays high for the whole read cycle.
// - Address valid before or with selects becoming active.
// - With gate low during write, drive data only after float delay.
`include "asm_defines.vh"

module asm_ctrl
(
    // Clock and reset
    input wire i_clk,
    input wire i_rst_b,
    // User request
    input wire i_req_valid,
    input wire i_req_write,
    input wire [`ASM_ADDR_W-1:0] i_req_addr,
    input wire [`ASM_DATA_W-1:0] i_req_wdata,
    output wire o_req_ready,
    output reg [`ASM_DATA_W-1:0] o_rd_data,
    output reg o_rd_valid,
    output reg o_wr_done,
    // Memory pins
    output reg [`ASM_ADDR_W-1:0] o_address_lines,
    output reg o_select_primary_n,
    output reg o_select_secondary,
    output reg o_gate_n,
    output reg o_write_strobe_n,
    input wire [`ASM_DATA_W-1:0] i_data_lines,
    output reg [`ASM_DATA_W-1:0] o_data_lines,
    output reg o_data_lines_oe
);

localparam ST_IDLE = 3'd0;
localparam ST_WSET = 3'd1;
localparam ST_WFLT = 3'd2;
localparam ST_WDAT = 3'd3;
localparam ST_READ = 3'd4;
localparam ST_TURN = 3'd5;

// Counts as integers first, then cut to the counter width
localparam integer FLOAT_CYC_I = `ASM_FLOAT_CYC;
localparam integer SETUP_CYC_I = `ASM_SETUP_CYC;
localparam integer STROBE_CYC_I = `ASM_STROBE_CYC;
localparam integer READ_CYC_I = `ASM_READ_CYC;
localparam integer TURN_CYC_I = `ASM_TURN_CYC;

localparam [7:0] FLOAT_CYC = FLOAT_CYC_I[7:0];
localparam [7:0] SETUP_CYC = SETUP_CYC_I[7:0];
localparam [7:0] STROBE_CYC = STROBE_CYC_I[7:0];
localparam [7:0] READ_CYC = READ_CYC_I[7:0];
localparam [7:0] TURN_CYC = TURN_CYC_I[7:0];

// Sequencer
reg [2:0] state_r;
reg [2:0] state_nxt;
reg [7:0] cnt_r;
reg [7:0] cnt_nxt;
reg [`ASM_DATA_W-1:0] wdata_r;
reg [`ASM_DATA_W-1:0] wdata_nxt;

// Next values of the output registers
reg [`ASM_ADDR_W-1:0] address_lines_nxt;
reg select_primary_n_nxt;
reg select_secondary_nxt;
reg gate_n_nxt;
reg write_strobe_n_nxt;
reg [`ASM_DATA_W-1:0] data_lines_nxt;
reg data_lines_oe_nxt;
reg [`ASM_DATA_W-1:0] rd_data_nxt;
reg rd_valid_nxt;
reg wr_done_nxt;

// Larger of two counts
function [7:0] max8;
    input [7:0] a;
    input [7:0] b;
    begin
        max8 = (a > b) ? a : b;
    end
endfunction

// Difference that stops at zero, so a float wait longer than the strobe minimum cannot wrap
function [7:0] sub_floor8;
    input [7:0] a;
    input [7:0] b;
    begin
        sub_floor8 = (a > b) ? (a - b) : 8'h00;
    end
endfunction

// A countdown ends in the cycle in which it holds one
function cnt_last;
    input [7:0] c;
    begin
        cnt_last = (c == 8'h01);
    end
endfunction

// One step down a countdown
function [7:0] cnt_dec;
    input [7:0] c;
    begin
        cnt_dec = c - 8'h01;
    end
endfunction

// Strobe spans float wait plus data setup, never below the pulse minimum
localparam [7:0] DATA_CYC = max8(SETUP_CYC, sub_floor8(STROBE_CYC, FLOAT_CYC));

assign o_req_ready = (state_r == ST_IDLE);

// State and countdown
always @*
begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    case (state_r)
        ST_IDLE:
        begin
            if (i_req_valid)
            begin
                if (i_req_write)
                begin
                    cnt_nxt = 8'h00;
                    state_nxt = ST_WSET;
                end
                else
                begin
                    cnt_nxt = READ_CYC;
                    state_nxt = ST_READ;
                end
            end
        end
        ST_WSET:
        begin
            cnt_nxt = FLOAT_CYC;
            state_nxt = ST_WFLT;
        end
        ST_WFLT:
        begin
            if (cnt_last(cnt_r))
            begin
                cnt_nxt = DATA_CYC;
                state_nxt = ST_WDAT;
            end
            else
                cnt_nxt = cnt_dec(cnt_r);
        end
        ST_WDAT:
        begin
            if (cnt_last(cnt_r))
            begin
                cnt_nxt = TURN_CYC;
                state_nxt = ST_TURN;
            end
            else
                cnt_nxt = cnt_dec(cnt_r);
        end
        ST_READ:
        begin
            if (cnt_last(cnt_r))
            begin
                cnt_nxt = TURN_CYC;
                state_nxt = ST_TURN;
            end
            else
                cnt_nxt = cnt_dec(cnt_r);
        end
        ST_TURN:
        begin
            if (cnt_last(cnt_r))
                state_nxt = ST_IDLE;
            else
                cnt_nxt = cnt_dec(cnt_r);
        end
        default:
        begin
            state_nxt = ST_IDLE;
        end
    endcase
end

// Pin levels and user answers
always @*
begin
    wdata_nxt = wdata_r;
    address_lines_nxt = o_address_lines;
    select_primary_n_nxt = o_select_primary_n;
    select_secondary_nxt = o_select_secondary;
    gate_n_nxt = o_gate_n;
    write_strobe_n_nxt = o_write_strobe_n;
    data_lines_nxt = o_data_lines;
    data_lines_oe_nxt = o_data_lines_oe;
    rd_data_nxt = o_rd_data;
    rd_valid_nxt = 1'b0;
    wr_done_nxt = 1'b0;
    case (state_r)
        ST_IDLE:
        begin
            if (i_req_valid)
            begin
                // Address moves on the edge that selects, never after it
                address_lines_nxt = i_req_addr;
                wdata_nxt = i_req_wdata;
                select_primary_n_nxt = 1'b0;
                select_secondary_nxt = 1'b1;
                gate_n_nxt = i_req_write;
                write_strobe_n_nxt = 1'b1;
            end
        end
        ST_WSET:
        begin
            // Strobe falls; bus left undriven until the device floats
            write_strobe_n_nxt = 1'b0;
        end
        ST_WFLT:
        begin
            if (cnt_last(cnt_r))
            begin
                data_lines_nxt = wdata_r;
                data_lines_oe_nxt = 1'b1;
            end
        end
        ST_WDAT:
        begin
            if (cnt_last(cnt_r))
            begin
                // Strobe and selects end together; address, data held to that edge
                write_strobe_n_nxt = 1'b1;
                select_primary_n_nxt = 1'b1;
                select_secondary_nxt = 1'b0;
                data_lines_oe_nxt = 1'b0;
                wr_done_nxt = 1'b1;
            end
        end
        ST_READ:
        begin
            if (cnt_last(cnt_r))
            begin
                rd_data_nxt = i_data_lines;
                rd_valid_nxt = 1'b1;
                select_primary_n_nxt = 1'b1;
                select_secondary_nxt = 1'b0;
                gate_n_nxt = 1'b1;
            end
        end
        ST_TURN:
        begin
            // Pins already idle; nothing moves until the device has floated
        end
        default:
        begin
            // Pins hold their levels
        end
    endcase
end

// Every pin and answer except o_req_ready comes straight from a flip-flop
always @(posedge i_clk or negedge i_rst_b)
begin
    if (!i_rst_b)
    begin
        state_r <= ST_IDLE;
        cnt_r <= 8'h00;
        wdata_r <= 8'h00;
        o_address_lines <= 20'h00000;
        o_select_primary_n <= 1'b1;
        o_select_secondary <= 1'b0;
        o_gate_n <= 1'b1;
        o_write_strobe_n <= 1'b1;
        o_data_lines <= 8'h00;
        o_data_lines_oe <= 1'b0;
        o_rd_data <= 8'h00;
        o_rd_valid <= 1'b0;
        o_wr_done <= 1'b0;
    end
    else
    begin
        state_r <= state_nxt;
        cnt_r <= cnt_nxt;
        wdata_r <= wdata_nxt;
        o_address_lines <= address_lines_nxt;
        o_select_primary_n <= select_primary_n_nxt;
        o_select_secondary <= select_secondary_nxt;
        o_gate_n <= gate_n_nxt;
        o_write_strobe_n <= write_strobe_n_nxt;
        o_data_lines <= data_lines_nxt;
        o_data_lines_oe <= data_lines_oe_nxt;
        o_rd_data <= rd_data_nxt;
        o_rd_valid <= rd_valid_nxt;
        o_wr_done <= wr_done_nxt;
    end
end

endmodule // asm_ctrl

// ### tb/asm_ctrl_checker.sv
module asm_ctrl_checker
(
    // Clock and reset
    input wire i_clk,
    input wire i_rst_b,
    // User side
    input wire i_req_valid,
    input wire i_req_write,
    input wire o_req_ready,
    input wire o_rd_valid,
    input wire o_wr_done,
    // Memory pins
    input wire o_select_primary_n,
    input wire o_select_secondary,
    input wire o_gate_n,
    input wire o_write_strobe_n,
    input wire o_data_lines_oe,
    input wire [19:0] o_address_lines,
    input wire [7:0] o_data_lines
);
    timeunit 1ns;
    timeprecision 1ns;
    wire sel = !o_select_primary_n && o_select_secondary;
    wire st = o_write_strobe_n;
    wire oe = o_data_lines_oe;
    wire tk = i_req_valid && o_req_ready;
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_b);
    a_write_answer: assert property (tk && i_req_write |-> ##7 o_wr_done) else $error("write late");
    a_read_answer: assert property (tk && !i_req_write |-> ##8 o_rd_valid) else $error("read late");
    a_strobe_width: assert property ($fell(st) |-> !st [*4]) else $error("strobe short");
    a_float_wait: assert property ($fell(st) |-> !oe [*2]) else $error("drive early");
    a_select_lead: assert property ($rose(st) |-> o_wr_done && $past(sel, 4)) else $error("select late");
    a_data_setup: assert property ($rose(st) |-> $past(oe, 3) && $past(o_data_lines, 3) == $past(o_data_lines))
        else $error("data setup short");
    a_addr_steady: assert property (sel && !$rose(sel) |-> $stable(o_address_lines)) else $error("addr moved");
    a_read_strobe: assert property (!o_gate_n |-> sel && st && !oe) else $error("strobe in read");
    a_drive_write: assert property (oe |-> sel && !st) else $error("drive outside write");
endmodule // asm_ctrl_checker
bind asm_ctrl asm_ctrl_checker chk_u (.*);

// ### tb/asm_mem_model.sv
module asm_mem_model
(
    // Clock
    input wire i_clk,
    // Control pins
    input wire i_select_primary_n,
    input wire i_select_secondary,
    input wire i_gate_n,
    input wire i_write_strobe_n,
    // Address and data
    input wire [19:0] i_address_lines,
    input wire [7:0] i_data_lines,
    output wire [7:0] o_data_lines
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [0:1048575];
    wire sel = !i_select_primary_n && i_select_secondary;
    wire drv = sel && !i_gate_n && i_write_strobe_n;
    wire ok;
    wire [7:0] rd = mem[i_address_lines];
    // Valid only after the access delay, floats at once
    assign #(55, 0) ok = drv;
    // A released bus shows the inverse, so a stray sample cannot match
    assign o_data_lines = ok ? rd : ~rd;
    always @(posedge i_clk)
        if (sel && !i_write_strobe_n)
            mem[i_address_lines] <= i_data_lines;
endmodule // asm_mem_model

// ### tb/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clk = 1'b0, i_rst_b = 1'b0, v = 1'b0, wr = 1'b0;
    logic [19:0] ad = 20'h0;
    logic [7:0] wd = 8'h0;
    wire [19:0] al;
    wire [7:0] od, md, q;
    wire sp_n, ss, g_n, s_n, oe, rdy, rv, dn;
    int n_mismatch = 0, n_tests = 0;
    always #5 i_clk = ~i_clk;
    asm_ctrl dut_u (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_req_valid(v), .i_req_write(wr), .i_req_addr(ad),
        .i_req_wdata(wd), .o_req_ready(rdy), .o_rd_data(q), .o_rd_valid(rv), .o_wr_done(dn),
        .o_address_lines(al), .o_select_primary_n(sp_n), .o_select_secondary(ss), .o_gate_n(g_n),
        .o_write_strobe_n(s_n), .i_data_lines(oe ? od : md), .o_data_lines(od), .o_data_lines_oe(oe));
    asm_mem_model mem_u (.i_clk(i_clk), .i_select_primary_n(sp_n), .i_select_secondary(ss), .i_gate_n(g_n),
        .i_write_strobe_n(s_n), .i_address_lines(al), .i_data_lines(oe ? od : ~od), .o_data_lines(md));
    task automatic chk(input string s, input logic [7:0] e, g);
        n_tests++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", s, e, g);
        end
    endtask
    // One whole request; the answer is waited for under a bound
    task automatic req(input logic w, input logic [19:0] a, input logic [7:0] d, e);
        logic [7:0] n;
        n = 8'h0;
        @(posedge i_clk);
        v <= 1'b1;
        wr <= w;
        ad <= a;
        wd <= d;
        do @(negedge i_clk); while (rdy !== 1'b1);
        @(posedge i_clk);
        v <= 1'b0;
        do @(negedge i_clk); while ((w ? dn : rv) !== 1'b1 && ++n < 8'h20);
        chk("latency", w ? 8'h6 : 8'h7, n);
        chk("ready", 8'h0, {7'h0, rdy});
        if (!w) chk("rdata", e, q);
    endtask
    task automatic t_bound;
        req(1'b1, 20'hfffff, 8'h5a, 8'h0);
        req(1'b1, 20'h00000, 8'ha5, 8'h0);
        req(1'b0, 20'hfffff, 8'h0, 8'h5a);
        req(1'b0, 20'h00000, 8'h0, 8'ha5);
        $display("test t_bound done");
    endtask
    task automatic t_over;
        req(1'b1, 20'h12345, 8'h01, 8'h0);
        req(1'b1, 20'h12345, 8'hfe, 8'h0);
        req(1'b0, 20'h12345, 8'h0, 8'hfe);
        req(1'b0, 20'h00000, 8'h0, 8'ha5);
        $display("test t_over done");
    endtask
    task automatic close_out;
        $display("mismatches %0d, comparisons %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        repeat (5) @(posedge i_clk);
        i_rst_b <= 1'b1;
        t_bound();
        t_over();
        close_out();
    end
    initial
    begin
        #5000;
        n_mismatch++;
        close_out();
    end
endmodule // testbench
